// File: include/acs_pkg.sv
// Shared constants and types for the conversion and sleep control block.
package acs_pkg;

    // Clock period, result width and counter widths.
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          RES_W           = 12;
    localparam int          TICK_W          = 4;
    localparam int          WAKE_W          = 8;

    // Successive-approximation step time and derived cycle count, rounded up.
    localparam int          BIT_TIME_NS     = 60;
    localparam int          BIT_CYC         = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  BIT_RELOAD      = 4'(BIT_CYC - 1);

    // Wake-up delays after leaving each kind of sleep, rounded up.
    localparam int          WAKE_PARTIAL_NS  = 200;
    localparam int          WAKE_FULL_NS     = 2000;
    localparam int          WAKE_PARTIAL_CYC = (WAKE_PARTIAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WAKE_FULL_CYC    = (WAKE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  WAKE_PARTIAL_RLD = 8'(WAKE_PARTIAL_CYC - 1);
    localparam logic [7:0]  WAKE_FULL_RLD    = 8'(WAKE_FULL_CYC - 1);

    // Reset values and bit patterns.
    localparam logic [11:0] RESULT_RST      = 12'h000;
    localparam logic [11:0] MSB_MASK        = 12'h800;
    localparam logic [11:0] LSB_MASK        = 12'h001;
    localparam logic [3:0]  TICK_RST        = 4'h0;
    localparam logic [7:0]  WAKE_RST        = 8'h00;

    // Control sequencer states.
    typedef enum logic [2:0] {
        ST_TRACK,
        ST_CONVERT,
        ST_LOAD,
        ST_SLEEP,
        ST_WAKE
    } acs_state_t;

endpackage : acs_pkg

// File: include/acs_sar_if.sv
// Link between the control sequencer and the successive-approximation engine.
`timescale 1ns/10ps
`default_nettype none
interface acs_sar_if;
    logic        start;
    logic        comp_above;
    logic        done;
    logic [11:0] code;

    modport ctrl (output start, output comp_above, input done, input code);
    modport eng  (input start, input comp_above, output done, output code);
endinterface : acs_sar_if
`default_nettype wire

// File: design/acs_sar_engine.sv
// Successive-approximation register that resolves one bit per step time.
`timescale 1ns/10ps
`default_nettype none
module acs_sar_engine
    import acs_pkg::*;
(
    // Clock and reset.
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // Sequencer link.
    acs_sar_if.eng    sar
);

    logic [11:0] code_ff;
    logic [11:0] mask_ff;
    logic [3:0]  tick_ff;
    logic        run_ff;
    logic        done_ff;
    logic [11:0] nxt_code;

    // A kept bit stays set when the input lies above the trial level.
    always_comb begin
        nxt_code = sar.comp_above ? code_ff : (code_ff & ~mask_ff);
        nxt_code = nxt_code | (mask_ff >> 1);
    end

    // A start restarts the search at once, even in the middle of a conversion.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            code_ff <= RESULT_RST;
            mask_ff <= RESULT_RST;
            tick_ff <= TICK_RST;
            run_ff  <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (sar.start) begin
                code_ff <= MSB_MASK;
                mask_ff <= MSB_MASK;
                tick_ff <= BIT_RELOAD;
                run_ff  <= 1'b1;
            end else if (run_ff) begin
                if (tick_ff == TICK_RST) begin
                    code_ff <= nxt_code;
                    mask_ff <= mask_ff >> 1;
                    tick_ff <= BIT_RELOAD;
                    if (mask_ff == LSB_MASK) begin
                        run_ff  <= 1'b0;
                        done_ff <= 1'b1;
                    end
                end else begin
                    tick_ff <= tick_ff - 4'h1;
                end
            end
        end
    end

    assign sar.code = code_ff;
    assign sar.done = done_ff;

endmodule : acs_sar_engine
`default_nettype wire

// File: design/acs_conv_ctrl.sv
// Conversion start, busy, sleep sequencing and result port of the converter.
`timescale 1ns/10ps
`default_nettype none
module acs_conv_ctrl
    import acs_pkg::*;
(
    // Clock and reset.
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    // Host control.
    input  wire logic              conversion_start_n_i,
    input  wire logic              sleep_type_select_i,
    output logic                   busy_o,
    output logic                   ready_o,
    // Result port.
    input  wire logic              chip_select_n_i,
    input  wire logic              read_n_i,
    output logic [RES_W-1:0]       result_bus_o,
    output logic                   result_bus_oe_o,
    // Analog front end.
    input  wire logic              comparator_above_i,
    output logic                   sampler_hold_o,
    output logic [RES_W-1:0]       dac_code_o,
    output logic                   analog_power_o,
    output logic                   ref_power_o,
    output logic                   osc_power_o
);

    localparam logic [7:0] WAKE_ONE = 8'h01;

    acs_sar_if sar ();

    acs_state_t        state_ff;
    acs_state_t        nxt_state;
    logic              start_n_prev_ff;
    logic              start_fall;
    logic              start_rise;
    logic              sleep_partial_ff;
    logic [7:0]        wake_cnt_ff;
    logic [RES_W-1:0]  result_ff;
    logic              read_active;

    acs_sar_engine u_engine (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .sar        (sar)
    );

    // The start pin is synchronous, so one sampled low level already forms an edge.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            start_n_prev_ff <= 1'b1;
        end else begin
            start_n_prev_ff <= conversion_start_n_i;
        end
    end

    assign start_fall = start_n_prev_ff & ~conversion_start_n_i;
    assign start_rise = ~start_n_prev_ff & conversion_start_n_i;

    // A falling edge in any state restarts the conversion at once.
    always_comb begin
        nxt_state = state_ff;
        if (start_fall) begin
            nxt_state = ST_CONVERT;
        end else begin
            case (state_ff)
                ST_TRACK: begin
                    nxt_state = ST_TRACK;
                end
                ST_CONVERT: begin
                    if (sar.done) begin
                        nxt_state = ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    nxt_state = conversion_start_n_i ? ST_TRACK : ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (start_rise) begin
                        nxt_state = ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (wake_cnt_ff == WAKE_RST) begin
                        nxt_state = ST_TRACK;
                    end
                end
                default: begin
                    nxt_state = ST_TRACK;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_TRACK;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // The sleep type is captured on entry so the wake delay matches the sleep taken.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sleep_partial_ff <= 1'b1;
        end else if (state_ff == ST_LOAD && nxt_state == ST_SLEEP) begin
            sleep_partial_ff <= sleep_type_select_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wake_cnt_ff <= WAKE_RST;
        end else if (state_ff == ST_SLEEP && start_rise) begin
            wake_cnt_ff <= sleep_partial_ff ? WAKE_PARTIAL_RLD : WAKE_FULL_RLD;
        end else if (state_ff == ST_WAKE && wake_cnt_ff != WAKE_RST) begin
            wake_cnt_ff <= wake_cnt_ff - WAKE_ONE;
        end
    end

    // The result changes only as a conversion completes, never during one.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            result_ff <= RESULT_RST;
        end else if (state_ff == ST_CONVERT && sar.done && !start_fall) begin
            result_ff <= sar.code;
        end
    end

    assign sar.start      = start_fall;
    assign sar.comp_above = comparator_above_i;
    assign dac_code_o     = sar.code;

    assign busy_o         = (state_ff == ST_CONVERT) || (state_ff == ST_LOAD);
    assign sampler_hold_o = (state_ff == ST_CONVERT);
    assign ready_o        = (state_ff == ST_TRACK);

    // Partial sleep keeps reference and oscillator alive; full sleep drops all analog.
    assign analog_power_o = (state_ff != ST_SLEEP);
    assign ref_power_o    = (state_ff != ST_SLEEP) || sleep_partial_ff;
    assign osc_power_o    = (state_ff != ST_SLEEP) || sleep_partial_ff;

    // Both active-low selects meet in one gate, so either may be tied low.
    assign read_active     = ~(chip_select_n_i | read_n_i);
    assign result_bus_oe_o = read_active;
    assign result_bus_o    = result_ff;

    a_fall_starts_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        start_fall |=> busy_o && sampler_hold_o && state_ff == ST_CONVERT)
        else $error("Start falling edge did not begin a held conversion.");

    a_short_pulse_trig: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (conversion_start_n_i ##1 !conversion_start_n_i ##1 conversion_start_n_i)
        |-> busy_o && sampler_hold_o && state_ff == ST_CONVERT)
        else $error("One-cycle start pulse was not taken as a trigger.");

    a_busy_through_conv: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == ST_CONVERT && !sar.done) |=> busy_o)
        else $error("Busy dropped before the conversion ended.");

    a_busy_fall_loaded: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(busy_o) |-> $past(state_ff == ST_LOAD) && result_ff == $past(sar.code, 2))
        else $error("Busy fell without a freshly loaded result.");

    a_track_before_fall: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(busy_o) |-> !sampler_hold_o && $past(!sampler_hold_o && busy_o))
        else $error("Sampler was not tracking one cycle before busy fell.");

    a_auto_sleep_entry: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == ST_LOAD && !conversion_start_n_i && !start_fall)
        |=> state_ff == ST_SLEEP && !busy_o)
        else $error("Start held low at end of conversion did not enter sleep.");

    a_sleep_power_kind: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == ST_LOAD && !conversion_start_n_i && !start_fall)
        |=> !analog_power_o && ref_power_o == $past(sleep_type_select_i)
            && osc_power_o == $past(sleep_type_select_i))
        else $error("Sleep power state does not match the select level.");

    a_wake_delay_load: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == ST_SLEEP && start_rise)
        |=> state_ff == ST_WAKE && analog_power_o
            && wake_cnt_ff == (sleep_partial_ff ? WAKE_PARTIAL_RLD : WAKE_FULL_RLD))
        else $error("Wake did not start with the delay of the sleep type.");

    a_wake_completes: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == ST_WAKE && wake_cnt_ff == WAKE_RST && !start_fall) |=> ready_o)
        else $error("Wake delay expired without returning to tracking.");

    a_bus_gated_read: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (chip_select_n_i || read_n_i || state_ff == ST_LOAD)
        |-> result_bus_oe_o == (!chip_select_n_i && !read_n_i))
        else $error("Result bus enabled without both selects low.");

    a_bus_stable_conv: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == ST_CONVERT && $past(state_ff == ST_CONVERT)) |-> $stable(result_bus_o))
        else $error("Result bus changed during a conversion.");

endmodule : acs_conv_ctrl
`default_nettype wire

// File: test/acs_analog_model.sv
// Behavioural comparator that stands in for the analog input of the converter.
`timescale 1ns/10ps
`default_nettype none
module acs_analog_model
    import acs_pkg::*;
(
    // Trial code from the converter.
    input  wire logic [RES_W-1:0] dac_code_i,
    // Level of the sampled input, in codes.
    input  wire logic [RES_W-1:0] level_i,
    // Comparator decision.
    output logic                  above_o
);
    // Input at or above the trial code keeps the bit, so the result equals the level.
    assign above_o = (level_i >= dac_code_i);
endmodule : acs_analog_model
`default_nettype wire

// File: test/adc_conversion_sleep_control_bench.sv
// Self-checking bench for the conversion and sleep control block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((ex) !== (got)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module adc_conversion_sleep_control_bench
    import acs_pkg::*;
;
    logic             core_clk_i = 1'b0;
    logic             rst_n_i    = 1'b0;
    logic             start_n    = 1'b1;
    logic             sel        = 1'b1;
    logic             cs_n       = 1'b1;
    logic             rd_n       = 1'b1;
    logic             busy, ready, oe, hold, apwr, rpwr, opwr, above, prev_busy;
    logic [RES_W-1:0] res, dac, exp_v;
    logic [RES_W-1:0] level      = 12'h000;
    logic [31:0]      seed       = 32'd46;
    logic [RES_W-1:0] exp_q[$];
    int               fails      = 0;
    int               tests_run  = 0;
    int               n;

    always #5 core_clk_i = ~core_clk_i;

    acs_conv_ctrl dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .conversion_start_n_i(start_n), .sleep_type_select_i(sel),
        .busy_o(busy), .ready_o(ready),
        .chip_select_n_i(cs_n), .read_n_i(rd_n),
        .result_bus_o(res), .result_bus_oe_o(oe),
        .comparator_above_i(above), .sampler_hold_o(hold), .dac_code_o(dac),
        .analog_power_o(apwr), .ref_power_o(rpwr), .osc_power_o(opwr)
    );

    acs_analog_model analog (.dac_code_i(dac), .level_i(level), .above_o(above));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // The strap only changes while the block is held in reset.
    task automatic do_reset(input logic s);
        @(negedge core_clk_i);
        rst_n_i = 1'b0;
        sel = s;
        repeat (12) @(negedge core_clk_i);
        rst_n_i = 1'b1;
    endtask : do_reset

    // One conversion; with stay_low the start stays low through the end of conversion.
    task automatic convert(input logic [RES_W-1:0] v, input logic stay_low);
        int  cnt;
        logic lh;
        @(negedge core_clk_i);
        level = v;
        start_n = 1'b0;
        exp_q.push_back(v);
        @(posedge core_clk_i);
        #1;
        `CHK("hold_at_start", 1'b1, hold)
        `CHK("dac_first_trial", MSB_MASK, dac)
        `CHK("busy_at_start", 1'b1, busy)
        if (!stay_low) begin
            @(negedge core_clk_i);
            start_n = 1'b1;
        end
        cnt = 1;
        lh = 1'b1;
        repeat (200) begin
            @(posedge core_clk_i);
            #1;
            if (busy !== 1'b1) break;
            cnt++;
            lh = hold;
        end
        // Busy also spans the cycle in which done reaches the sequencer and the load cycle.
        `CHK("busy_length", RES_W * BIT_CYC + 2, cnt)
        `CHK("hold_before_fall", 1'b0, lh)
        if (cnt > 150) finish_test();
        if (!stay_low) `CHK("ready_after", 1'b1, ready)
    endtask : convert

    task automatic sleep_cycle(input logic s);
        int lim;
        do_reset(s);
        seed = xs(seed);
        convert(seed[RES_W-1:0], 1'b1);
        `CHK("analog_power", 1'b0, apwr)
        `CHK("ref_power", s, rpwr)
        `CHK("osc_power", s, opwr)
        `CHK("ready_asleep", 1'b0, ready)
        lim = s ? WAKE_PARTIAL_CYC : WAKE_FULL_CYC;
        @(negedge core_clk_i);
        start_n = 1'b1;
        n = 0;
        repeat (400) begin
            @(posedge core_clk_i);
            #1;
            n++;
            if (ready === 1'b1) break;
        end
        `CHK("wake_time", 1'b1, (n >= lim && n <= lim + 3))
        `CHK("power_awake", 1'b1, apwr & rpwr & opwr)
        if (n >= 400) finish_test();
    endtask : sleep_cycle

    // Each falling edge of busy delivers the oldest expected result; sampled off the clock edge.
    always @(negedge core_clk_i) begin
        if (prev_busy === 1'b1 && busy === 1'b0) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("wrong value result_queue expected 1 seen 0");
            end else begin
                exp_v = exp_q.pop_front();
                `CHK("result", exp_v, res)
            end
        end
        prev_busy <= busy;
    end

    initial begin
        repeat (12) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk_i);
            {cs_n, rd_n} = 2'(i);
            #1;
            `CHK("bus_enable", (i == 0), oe)
        end
        convert(12'h000, 1'b0);
        convert(12'hFFF, 1'b0);
        repeat (4) begin
            seed = xs(seed);
            convert(seed[RES_W-1:0], 1'b0);
        end
        // A second falling edge restarts the conversion; only its result is expected.
        @(negedge core_clk_i);
        level = 12'h555;
        start_n = 1'b0;
        @(negedge core_clk_i);
        start_n = 1'b1;
        repeat (20) @(negedge core_clk_i);
        convert(12'hA3C, 1'b0);
        sleep_cycle(1'b1);
        sleep_cycle(1'b0);
        finish_test();
    end
endmodule : adc_conversion_sleep_control_bench
`default_nettype wire
